// file: pkg/spf_map.vh
`ifndef SPF_MAP_VH
`define SPF_MAP_VH
`define SPF_OFS_STATUS 8'h00
`define SPF_OFS_MASK 8'h04
`define SPF_OFS_CTRL 8'h08
`define SPF_OFS_INFO 8'h0c
`define SPF_RESP_OK 2'b00
`define SPF_RESP_ERR 2'b10
`define SPF_FLG_DEN 0
`define SPF_FLG_DZ 1
`define SPF_FLG_OF 2
`define SPF_FLG_UF 3
`define SPF_FLG_INV 4
`define SPF_OP_ADD 4'h0
`define SPF_OP_SUB 4'h1
`define SPF_OP_MUL 4'h2
`define SPF_OP_DIV 4'h3
`define SPF_OP_SQRT 4'h4
`define SPF_OP_LT 4'h5
`define SPF_OP_EQ 4'h6
`define SPF_OP_LE 4'h7
`define SPF_OP_GT 4'h8
`define SPF_OP_NE 4'h9
`define SPF_OP_GE 4'ha
`define SPF_OP_UN 4'hb
`define SPF_OP_FLT 4'hc
`define SPF_OP_FINT 4'hd
`define SPF_CFG_EXT 2'h2
`define SPF_QNAN 32'hffc00000
`define SPF_INF 31'h7f800000
`define SPF_EXP_MAX 8'hff
`define SPF_BIAS 11'sh07f
`define SPF_LEAD 11'sh01e
`define SPF_FINT_SH 11'sh009
`define SPF_ITER 5'h1b
`define SPF_INT_MAX 32'h7fffffff
`define SPF_INT_MIN 32'h80000000
`endif

// file: verilog/spf_pack.v
`timescale 1ns/100ps
`default_nettype none
`include "spf_map.vh"
module spf_pack (
  input wire sgn,
  input wire signed [10:0] exp_in,
  input wire [31:0] man,
  output reg [31:0] word,
  output reg uf,
  output reg of
);
  integer i;
  reg [4:0] p;
  reg [31:0] m2;
  reg [24:0] r;
  reg rnd;
  reg signed [10:0] e2;
  always @* begin
    p = 5'h00;
    for (i = 0; i < 32; i = i + 1) begin
      if (man[i]) p = i[4:0];
    end
    m2 = man << (5'h1f - p);
    // nearest, ties to the even candidate
    rnd = m2[7] & ((|m2[6:0]) | m2[8]);
    r = {1'b0, m2[31:8]} + {24'h000000, rnd};
    e2 = exp_in + $signed({6'h00, p}) - `SPF_LEAD + $signed({10'h000, r[24]});
    uf = 1'b0;
    of = 1'b0;
    word = {sgn, e2[7:0], r[22:0]};
    if (man == 32'h00000000) begin
      word = {sgn, 31'h00000000};
    end else if (e2 <= 11'sh000) begin
      word = {sgn, 31'h00000000};
      uf = 1'b1;
    end else if (e2 >= $signed({3'h0, `SPF_EXP_MAX})) begin
      word = {sgn, `SPF_INF};
      of = 1'b1;
    end
  end
endmodule // spf_pack
`default_nettype wire

// file: verilog/spf_iter.v
`timescale 1ns/100ps
`default_nettype none
`include "spf_map.vh"
module spf_iter (
  input wire aclk,
  input wire aresetn,
  input wire start,
  input wire sqrt_mode,
  input wire odd,
  input wire [23:0] opa,
  input wire [23:0] opb,
  output reg done_ff,
  output reg [26:0] quot_ff,
  output wire rem_nz
);
  reg run_ff;
  reg mode_ff;
  reg [4:0] cnt_ff;
  reg [28:0] rem_ff;
  reg [23:0] den_ff;
  reg [53:0] rad_ff;
  // restoring divide and restoring square root, one bit a cycle
  wire [28:0] r2 = {rem_ff[26:0], rad_ff[53:52]};
  wire [28:0] t2 = {quot_ff, 2'b01};
  wire sge = r2 >= t2;
  wire dge = rem_ff >= {5'h00, den_ff};
  wire [28:0] dsub = dge ? rem_ff - {5'h00, den_ff} : rem_ff;
  wire ge = mode_ff ? sge : dge;
  wire [28:0] nxt_rem = mode_ff ? (sge ? r2 - t2 : r2) : {dsub[27:0], 1'b0};
  assign rem_nz = |rem_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_ff <= 1'b0;
      mode_ff <= 1'b0;
      cnt_ff <= 5'h00;
      rem_ff <= 29'h0;
      den_ff <= 24'h0;
      rad_ff <= 54'h0;
      quot_ff <= 27'h0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start) begin
        run_ff <= 1'b1;
        mode_ff <= sqrt_mode;
        cnt_ff <= `SPF_ITER;
        quot_ff <= 27'h0;
        den_ff <= opb;
        rem_ff <= sqrt_mode ? 29'h0 : {5'h00, opa};
        rad_ff <= odd ? {opa, 30'h0} : {1'b0, opa, 29'h0};
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 5'h01;
        quot_ff <= {quot_ff[25:0], ge};
        rem_ff <= nxt_rem;
        rad_ff <= {rad_ff[51:0], 2'b00};
        if (cnt_ff == 5'h01) begin
          run_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
endmodule // spf_iter
`default_nettype wire

// file: verilog/spf_fpu.v
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "spf_map.vh"
module spf_fpu #(
  parameter [1:0] fpu_config_level = `SPF_CFG_EXT
) (
  input wire aclk,
  input wire aresetn,
  input wire issue_valid,
  input wire [3:0] issue_op,
  input wire [31:0] issue_opa,
  input wire [31:0] issue_opb,
  input wire [4:0] issue_rd,
  output reg stall_ff,
  output reg gpr_we_ff,
  output reg [4:0] gpr_waddr_ff,
  output reg [31:0] gpr_wdata_ff,
  output reg hw_exc_ff,
  output reg [4:0] exc_cause_ff,
  output reg irq_ff,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_CALC = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // {nan, inf, zero, denormal}
  function [3:0] spf_cls;
    input [31:0] x;
    begin
      spf_cls = {x[30:23] == `SPF_EXP_MAX && x[22:0] != 23'h0, x[30:23] == `SPF_EXP_MAX && x[22:0] == 23'h0,
        x[30:0] == 31'h0, x[30:23] == 8'h00 && x[22:0] != 23'h0};
    end
  endfunction

  // ordered key, both zeros map alike
  function [31:0] spf_key;
    input [31:0] x;
    begin
      if (x[30:0] == 31'h0) spf_key = `SPF_INT_MIN;
      else if (x[31]) spf_key = ~x;
      else spf_key = {1'b1, x[30:0]};
    end
  endfunction

  reg [1:0] st_ff;
  reg [3:0] op_ff;
  reg [31:0] a_ff;
  reg [31:0] b_ff;
  reg [4:0] rd_ff;
  reg [4:0] status_ff;
  reg [4:0] mask_ff;
  reg [4:0] ctrl_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  wire ext_ok = fpu_config_level == `SPF_CFG_EXT;
  wire sa = a_ff[31];
  wire sb = b_ff[31];
  wire [7:0] ea = a_ff[30:23];
  wire [7:0] eb = b_ff[30:23];
  wire [23:0] ma = {ea != 8'h00, a_ff[22:0]};
  wire [23:0] mb = {eb != 8'h00, b_ff[22:0]};
  wire [3:0] ca = spf_cls(a_ff);
  wire [3:0] cb = spf_cls(b_ff);
  wire sn = (ca[3] & ~a_ff[22]) | (cb[3] & ~b_ff[22]);
  wire sbe = sb ^ (op_ff == `SPF_OP_SUB);
  wire sx = sa ^ sb;
  wire signed [10:0] eu = $signed({3'h0, ea}) - `SPF_BIAS;
  wire odd = eu[0];
  wire [31:0] ka = spf_key(a_ff);
  wire [31:0] kb = spf_key(b_ff);
  wire lt = ka < kb;
  wire eq = ka == kb;
  wire un = ca[3] | cb[3];

  reg spec;
  reg [31:0] sw;
  reg [4:0] sfl;
  reg cmp_r;
  reg cmp_ord;
  always @* begin
    cmp_ord = 1'b1;
    case (op_ff)
      `SPF_OP_LT: cmp_r = lt;
      `SPF_OP_EQ: begin
        cmp_r = eq;
        cmp_ord = 1'b0;
      end
      `SPF_OP_LE: cmp_r = lt | eq;
      `SPF_OP_GT: cmp_r = ~lt & ~eq;
      `SPF_OP_NE: begin
        cmp_r = ~eq;
        cmp_ord = 1'b0;
      end
      `SPF_OP_GE: cmp_r = ~lt;
      default: begin
        cmp_r = 1'b0;
        cmp_ord = 1'b0;
      end
    endcase
    if (un) cmp_r = (op_ff == `SPF_OP_NE) | (op_ff == `SPF_OP_UN);
  end

  // float to signed integer, nearest even, saturating
  reg fint_inv;
  reg fr;
  reg [63:0] ft;
  reg [32:0] fmag;
  reg [31:0] fint_w;
  always @* begin
    fint_inv = 1'b0;
    ft = 64'h0;
    fmag = 33'h0;
    if (ca[3] | ca[2] | (eu > `SPF_LEAD)) begin
      fint_inv = 1'b1;
    end else if (eu >= -11'sh001) begin
      ft = {40'h0, ma} << (eu + `SPF_FINT_SH);
    end
    fr = ft[31] & ((|ft[30:0]) | ft[32]);
    fmag = {1'b0, ft[63:32]} + {32'h0, fr};
    if (fmag > {1'b0, sa ? `SPF_INT_MIN : `SPF_INT_MAX}) fint_inv = 1'b1;
    fint_w = fint_inv ? (sa ? `SPF_INT_MIN : `SPF_INT_MAX) : (sa ? 32'h0 - fmag[31:0] : fmag[31:0]);
  end

  always @* begin
    spec = 1'b1;
    sw = `SPF_QNAN;
    sfl = 5'h00;
    case (op_ff)
      `SPF_OP_ADD, `SPF_OP_SUB: begin
        if (ca[0] | cb[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else if (un) sfl[`SPF_FLG_INV] = sn;
        else if (ca[2] & cb[2] & (sa != sbe)) sfl[`SPF_FLG_INV] = 1'b1;
        else if (ca[2]) sw = a_ff;
        else if (cb[2]) sw = {sbe, b_ff[30:0]};
        else if (ca[1] & cb[1]) sw = {sa & sbe, 31'h0};
        else if (ca[1]) sw = {sbe, b_ff[30:0]};
        else if (cb[1]) sw = a_ff;
        else spec = 1'b0;
      end
      `SPF_OP_MUL: begin
        if (ca[0] | cb[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else if (un) sfl[`SPF_FLG_INV] = sn;
        else if ((ca[2] & cb[1]) | (ca[1] & cb[2])) sfl[`SPF_FLG_INV] = 1'b1;
        else if (ca[2] | cb[2]) sw = {sx, `SPF_INF};
        else if (ca[1] | cb[1]) sw = {sx, 31'h0};
        else spec = 1'b0;
      end
      `SPF_OP_DIV: begin
        if (ca[0] | cb[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else if (un) sfl[`SPF_FLG_INV] = sn;
        else if ((ca[2] & cb[2]) | (ca[1] & cb[1])) sfl[`SPF_FLG_INV] = 1'b1;
        else if (cb[1]) begin
          sfl[`SPF_FLG_DZ] = 1'b1;
          sw = {sx, `SPF_INF};
        end else if (ca[2]) sw = {sx, `SPF_INF};
        else if (ca[1] | cb[2]) sw = {sx, 31'h0};
        else spec = 1'b0;
      end
      `SPF_OP_SQRT: begin
        if (!ext_ok) sfl[`SPF_FLG_INV] = 1'b1;
        else if (ca[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else if (ca[3]) sfl[`SPF_FLG_INV] = ~a_ff[22];
        else if (ca[1]) sw = a_ff;
        else if (sa) sfl[`SPF_FLG_INV] = 1'b1;
        else if (ca[2]) sw = a_ff;
        else spec = 1'b0;
      end
      `SPF_OP_LT, `SPF_OP_EQ, `SPF_OP_LE, `SPF_OP_GT, `SPF_OP_NE, `SPF_OP_GE, `SPF_OP_UN: begin
        if (ca[0] | cb[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else begin
          sw = {31'h0, cmp_r};
          sfl[`SPF_FLG_INV] = (un & cmp_ord) | sn;
        end
      end
      `SPF_OP_FLT: begin
        if (!ext_ok) sfl[`SPF_FLG_INV] = 1'b1;
        else if (a_ff == 32'h0) sw = 32'h0;
        else spec = 1'b0;
      end
      `SPF_OP_FINT: begin
        if (!ext_ok) sfl[`SPF_FLG_INV] = 1'b1;
        else if (ca[0]) sfl[`SPF_FLG_DEN] = 1'b1;
        else begin
          sw = fint_w;
          sfl[`SPF_FLG_INV] = fint_inv;
        end
      end
      default: sfl[`SPF_FLG_INV] = 1'b1;
    endcase
  end

  wire it_done;
  wire [26:0] it_q;
  wire it_nz;
  wire is_iter = (op_ff == `SPF_OP_DIV) | (op_ff == `SPF_OP_SQRT);
  wire it_start = (st_ff == ST_CALC) & ~spec & is_iter;
  spf_iter u_iter (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(it_start),
    .sqrt_mode(op_ff == `SPF_OP_SQRT),
    .odd(odd),
    .opa(ma),
    .opb(mb),
    .done_ff(it_done),
    .quot_ff(it_q),
    .rem_nz(it_nz)
  );

  // operands for normalise and round
  reg big;
  reg [7:0] d;
  reg [31:0] mxs;
  reg [31:0] mys;
  reg [31:0] shs;
  reg [31:0] sum;
  reg [47:0] prod;
  reg signed [10:0] eh;
  reg pk_s;
  reg signed [10:0] pk_e;
  reg [31:0] pk_m;
  always @* begin
    big = a_ff[30:0] >= b_ff[30:0];
    d = big ? ea - eb : eb - ea;
    mxs = {1'b0, big ? ma : mb, 7'h00};
    mys = {1'b0, big ? mb : ma, 7'h00};
    if (d > 8'h1f) shs = {31'h0, |mys};
    else shs = (mys >> d) | {31'h0, |(mys & ((32'h1 << d) - 32'h1))};
    sum = (sa == sbe) ? mxs + shs : mxs - shs;
    prod = ma * mb;
    eh = (eu - $signed({10'h000, odd})) >>> 1;
    pk_s = sx;
    pk_e = $signed({3'h0, ea}) - $signed({3'h0, eb}) + `SPF_BIAS;
    pk_m = {1'b0, it_q, 4'h0} | {31'h0, it_nz};
    case (op_ff)
      `SPF_OP_ADD, `SPF_OP_SUB: begin
        pk_s = (sum == 32'h0) ? 1'b0 : (big ? sa : sbe);
        pk_e = $signed({3'h0, big ? ea : eb});
        pk_m = sum;
      end
      `SPF_OP_MUL: begin
        pk_e = $signed({3'h0, ea}) + $signed({3'h0, eb}) - `SPF_BIAS;
        pk_m = prod[47:16] | {31'h0, |prod[15:0]};
      end
      `SPF_OP_SQRT: begin
        pk_s = 1'b0;
        pk_e = eh + `SPF_BIAS;
      end
      `SPF_OP_FLT: begin
        pk_s = sa;
        pk_e = `SPF_BIAS + `SPF_LEAD;
        pk_m = sa ? 32'h0 - a_ff : a_ff;
      end
      default: pk_s = sx;
    endcase
  end

  wire [31:0] pk_w;
  wire pk_uf;
  wire pk_of;
  spf_pack u_pack (
    .sgn(pk_s),
    .exp_in(pk_e),
    .man(pk_m),
    .word(pk_w),
    .uf(pk_uf),
    .of(pk_of)
  );

  reg [4:0] res_fl;
  always @* begin
    res_fl = sfl;
    if (!spec) begin
      res_fl[`SPF_FLG_UF] = pk_uf;
      res_fl[`SPF_FLG_OF] = pk_of;
    end
  end
  wire [31:0] res_w = spec ? sw : pk_w;
  wire exc = |(res_fl & ctrl_ff);
  wire fin = ((st_ff == ST_CALC) & ~it_start) | ((st_ff == ST_WAIT) & it_done);
  wire take = issue_valid & (st_ff == ST_IDLE);

  reg [1:0] nxt_st;
  always @* begin
    case (st_ff)
      ST_IDLE: nxt_st = take ? ST_CALC : ST_IDLE;
      ST_CALC: nxt_st = it_start ? ST_WAIT : ST_IDLE;
      ST_WAIT: nxt_st = it_done ? ST_IDLE : ST_WAIT;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= ST_IDLE;
      op_ff <= 4'h0;
      a_ff <= 32'h0;
      b_ff <= 32'h0;
      rd_ff <= 5'h00;
      stall_ff <= 1'b0;
      gpr_we_ff <= 1'b0;
      gpr_waddr_ff <= 5'h00;
      gpr_wdata_ff <= 32'h0;
      hw_exc_ff <= 1'b0;
      exc_cause_ff <= 5'h00;
    end else begin
      st_ff <= nxt_st;
      gpr_we_ff <= 1'b0;
      hw_exc_ff <= 1'b0;
      if (take) begin
        op_ff <= issue_op;
        a_ff <= issue_opa;
        b_ff <= issue_opb;
        rd_ff <= issue_rd;
        stall_ff <= 1'b1;
      end
      if (fin) begin
        stall_ff <= 1'b0;
        gpr_we_ff <= ~exc;
        gpr_waddr_ff <= rd_ff;
        gpr_wdata_ff <= res_w;
        hw_exc_ff <= exc;
        exc_cause_ff <= res_fl & ctrl_ff;
      end
    end
  end

  // register slave
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire st_clr = rd_take & (s_axi_araddr == `SPF_OFS_STATUS);
  wire [4:0] st_set = fin ? res_fl : 5'h00;
  wire [4:0] nxt_status = (status_ff & ~{5{st_clr}}) | st_set;
  wire do_wr = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_ok = (awaddr_ff == `SPF_OFS_MASK) | (awaddr_ff == `SPF_OFS_CTRL);
  reg [31:0] rd_mux;
  reg rd_ok;
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `SPF_OFS_STATUS: rd_mux = {27'h0, status_ff};
      `SPF_OFS_MASK: rd_mux = {27'h0, mask_ff};
      `SPF_OFS_CTRL: rd_mux = {27'h0, ctrl_ff};
      `SPF_OFS_INFO: rd_mux = {29'h0, st_ff != ST_IDLE, fpu_config_level};
      default: begin
        rd_mux = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status_ff <= 5'h00;
      mask_ff <= 5'h00;
      ctrl_ff <= 5'h00;
      irq_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SPF_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `SPF_RESP_OK;
    end else begin
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & mask_ff);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `SPF_RESP_OK : `SPF_RESP_ERR;
        if (wstrb_ff[0] & (awaddr_ff == `SPF_OFS_MASK)) mask_ff <= wdata_ff[4:0];
        if (wstrb_ff[0] & (awaddr_ff == `SPF_OFS_CTRL)) ctrl_ff <= wdata_ff[4:0];
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `SPF_RESP_OK : `SPF_RESP_ERR;
      end
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // spf_fpu
`default_nettype wire

// file: verification/spf_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
// pipeline side: one fp op at a time, waits for the answer
module spf_pipe_model (
  input wire logic aclk,
  input wire logic stall_ff,
  input wire logic gpr_we_ff,
  input wire logic hw_exc_ff,
  input wire logic [4:0] gpr_waddr_ff,
  input wire logic [31:0] gpr_wdata_ff,
  input wire logic [4:0] exc_cause_ff,
  output logic issue_valid,
  output logic [3:0] issue_op,
  output logic [31:0] issue_opa,
  output logic [31:0] issue_opb,
  output logic [4:0] issue_rd
);
  initial begin
    {issue_valid, issue_op, issue_opa, issue_opb, issue_rd} = '0;
  end
  task automatic exec(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic [4:0] rd,
    output logic [31:0] res, output logic [4:0] cause, output logic [4:0] wa, output logic e, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge aclk);
    issue_op <= op;
    issue_opa <= a;
    issue_opb <= b;
    issue_rd <= rd;
    issue_valid <= 1'b1;
    // unit idle here, so this edge takes the op
    @(posedge aclk);
    issue_valid <= 1'b0;
    issue_opa <= ~a;
    issue_opb <= ~b;
    // no new op until the answer pulse
    for (n = 0; n < 64 && !ok; n++) begin
      @(negedge aclk);
      ok = gpr_we_ff || hw_exc_ff;
    end
    res = gpr_wdata_ff;
    cause = exc_cause_ff;
    wa = gpr_waddr_ff;
    e = hw_exc_ff;
  endtask
endmodule // spf_pipe_model
`default_nettype wire

// file: verification/spf_fpu_monitor.sv
`timescale 1ns/100ps
`default_nettype none
`include "spf_map.vh"
module spf_fpu_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic issue_valid,
  input wire logic [3:0] issue_op,
  input wire logic [31:0] issue_opa,
  input wire logic [31:0] issue_opb,
  input wire logic [4:0] issue_rd,
  input wire logic stall_ff,
  input wire logic gpr_we_ff,
  input wire logic [4:0] gpr_waddr_ff,
  input wire logic [31:0] gpr_wdata_ff,
  input wire logic hw_exc_ff,
  input wire logic [4:0] exc_cause_ff
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wire take = issue_valid && !stall_ff;
  wire done = gpr_we_ff || hw_exc_ff;
  wire long_op = issue_op == `SPF_OP_DIV || issue_op == `SPF_OP_SQRT;
  wire add_op = take && issue_op == `SPF_OP_ADD;
  wire prod_sgn = issue_opa[31] ^ issue_opb[31];
  sequence s_busy;
    stall_ff && !done;
  endsequence
  sequence s_end;
    !stall_ff && done;
  endsequence
  AST_EXC_NO_WRITE: assert property (!(gpr_we_ff && hw_exc_ff))
    else $error("write and exception together");
  AST_SHORT_OP: assert property (take && !long_op |=> s_busy ##1 s_end ##0
    (hw_exc_ff || gpr_waddr_ff == $past(issue_rd, 2))) else $error("short op timing");
  AST_LONG_OP: assert property (take && long_op |=> s_busy ##[1:29] s_end)
    else $error("long op timing");
  AST_ONE_PULSE: assert property (done |=> !done)
    else $error("answer longer than a cycle");
  AST_STALL_QUIET: assert property (stall_ff |-> !done)
    else $error("answer during stall");
  AST_QNAN: assert property (add_op && issue_opa[30:22] == 9'h1ff |->
    ##2 (hw_exc_ff || gpr_wdata_ff == `SPF_QNAN)) else $error("nan not fixed pattern");
  AST_DEN_IN: assert property (add_op && issue_opa[30:23] == 8'h00 && issue_opa[22:0] != 23'h0 |->
    ##2 (hw_exc_ff ? exc_cause_ff[`SPF_FLG_DEN] : gpr_wdata_ff == `SPF_QNAN)) else $error("denormal input");
  AST_MUL_OVF: assert property (take && issue_op == `SPF_OP_MUL && issue_opa[30:23] == 8'hfe &&
    issue_opb[30:23] == 8'hfe |-> ##2 (hw_exc_ff ? exc_cause_ff[`SPF_FLG_OF] :
    gpr_wdata_ff == {$past(prod_sgn, 2), `SPF_INF})) else $error("overflow not infinity");
  AST_ZERO: assert property (add_op && issue_opa[30:0] == 31'h0 && issue_opa == issue_opb |->
    ##2 (hw_exc_ff || gpr_wdata_ff == $past(issue_opa, 2))) else $error("signed zero sum");
endmodule // spf_fpu_monitor
bind spf_fpu spf_fpu_monitor spf_fpu_monitor_i (.aclk(aclk), .aresetn(aresetn), .issue_valid(issue_valid),
  .issue_op(issue_op), .issue_opa(issue_opa), .issue_opb(issue_opb), .issue_rd(issue_rd), .stall_ff(stall_ff),
  .gpr_we_ff(gpr_we_ff), .gpr_waddr_ff(gpr_waddr_ff), .gpr_wdata_ff(gpr_wdata_ff), .hw_exc_ff(hw_exc_ff),
  .exc_cause_ff(exc_cause_ff));
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "spf_map.vh"
module testbench;
  logic aclk, aresetn, issue_valid, stall_ff, gpr_we_ff, hw_exc_ff, irq_ff;
  logic [3:0] issue_op, s_axi_wstrb;
  logic [31:0] issue_opa, issue_opb, gpr_wdata_ff, s_axi_wdata, s_axi_rdata;
  logic [4:0] issue_rd, gpr_waddr_ff, exc_cause_ff;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_fail = 0;
  int compares = 0;
  spf_fpu spf_fpu_i (.aclk, .aresetn, .issue_valid, .issue_op, .issue_opa, .issue_opb, .issue_rd, .stall_ff,
    .gpr_we_ff, .gpr_waddr_ff, .gpr_wdata_ff, .hw_exc_ff, .exc_cause_ff, .irq_ff, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  spf_pipe_model spf_pipe_model_i (.aclk, .stall_ff, .gpr_we_ff, .hw_exc_ff, .gpr_waddr_ff, .gpr_wdata_ff,
    .exc_cause_ff, .issue_valid, .issue_op, .issue_opa, .issue_opb, .issue_rd);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic fail(input string m);
    n_fail++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] x, input logic [31:0] g, input string m);
    compares++;
    if (g !== x) fail($sformatf("%s exp %h got %h", m, x, g));
  endtask
  // one register access; for a read d is the expected word
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw, w, ar, hs;
    logic [31:0] q;
    logic [1:0] r;
    hs = 1'b0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (n = 0; n < 50 && !hs; n++) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      ar = s_axi_arvalid && s_axi_arready;
      hs = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
      if (hs) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (hs !== 1'b1) begin
      fail("bus timeout");
      stop_test();
    end
    chk({30'h0, er}, {30'h0, r}, "resp");
    if (!wr) chk(d, q, "rdata");
  endtask
  task automatic run(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] x, input logic xe);
    logic [31:0] res;
    logic [4:0] c, wa;
    logic e, ok;
    spf_pipe_model_i.exec(op, a, b, {1'b1, op}, res, c, wa, e, ok);
    if (ok !== 1'b1) begin
      fail("no answer");
      stop_test();
    end
    chk({31'h0, xe}, {31'h0, e}, "exception");
    if (xe) chk(x, {27'h0, c}, "cause");
    else chk(x, res, "result");
    if (!xe) chk({28'h1, op}, {27'h0, wa}, "dest");
  endtask
  task automatic t_reset;
    chk(32'h1c, {23'h0, stall_ff, gpr_we_ff, hw_exc_ff, irq_ff, s_axi_awready, s_axi_wready, s_axi_arready,
      s_axi_bvalid, s_axi_rvalid}, "reset outputs");
    bus(1'b0, `SPF_OFS_STATUS, 32'h0, `SPF_RESP_OK);
    bus(1'b0, `SPF_OFS_MASK, 32'h0, `SPF_RESP_OK);
    bus(1'b0, `SPF_OFS_CTRL, 32'h0, `SPF_RESP_OK);
    bus(1'b0, `SPF_OFS_INFO, 32'h2, `SPF_RESP_OK);
    bus(1'b0, 8'h10, 32'h0, `SPF_RESP_ERR);
  endtask
  task automatic t_arith;
    run(`SPF_OP_ADD, 32'h3f800000, 32'h40000000, 32'h40400000, 1'b0);
    run(`SPF_OP_SUB, 32'h40400000, 32'h40a00000, 32'hc0000000, 1'b0);
    run(`SPF_OP_MUL, 32'h3fc00000, 32'h3fc00000, 32'h40100000, 1'b0);
    run(`SPF_OP_DIV, 32'h3f800000, 32'h40400000, 32'h3eaaaaab, 1'b0);
    run(`SPF_OP_SQRT, 32'h40000000, 32'h0, 32'h3fb504f3, 1'b0);
    run(`SPF_OP_ADD, 32'h3f800000, 32'h33800000, 32'h3f800000, 1'b0);
    run(`SPF_OP_ADD, 32'h3f800000, 32'h34400000, 32'h3f800002, 1'b0);
    run(`SPF_OP_ADD, 32'h80000000, 32'h80000000, 32'h80000000, 1'b0);
    run(`SPF_OP_SUB, 32'h3f800000, 32'h3f800000, 32'h0, 1'b0);
  endtask
  task automatic t_cmp;
    run(`SPF_OP_LT, 32'h3f800000, 32'h40000000, 32'h1, 1'b0);
    run(`SPF_OP_EQ, 32'h3f800000, 32'h3f800000, 32'h1, 1'b0);
    run(`SPF_OP_LE, 32'h40000000, 32'h3f800000, 32'h0, 1'b0);
    run(`SPF_OP_GT, 32'h40000000, 32'h3f800000, 32'h1, 1'b0);
    run(`SPF_OP_NE, 32'h3f800000, 32'h3f800000, 32'h0, 1'b0);
    run(`SPF_OP_GE, 32'h3f800000, 32'h3f800000, 32'h1, 1'b0);
    run(`SPF_OP_UN, 32'h7fc00000, 32'h3f800000, 32'h1, 1'b0);
  endtask
  task automatic t_conv;
    run(`SPF_OP_FLT, 32'hfffffffb, 32'h0, 32'hc0a00000, 1'b0);
    run(`SPF_OP_FLT, 32'h01000001, 32'h0, 32'h4b800000, 1'b0);
    run(`SPF_OP_FINT, 32'h40200000, 32'h0, 32'h2, 1'b0);
    run(`SPF_OP_FINT, 32'hc0400000, 32'h0, 32'hfffffffd, 1'b0);
  endtask
  task automatic t_special;
    bus(1'b1, `SPF_OFS_MASK, 32'h4, `SPF_RESP_OK);
    run(`SPF_OP_ADD, 32'h7fc00000, 32'h3f800000, `SPF_QNAN, 1'b0);
    bus(1'b0, `SPF_OFS_STATUS, 32'h0, `SPF_RESP_OK);
    run(`SPF_OP_ADD, 32'h00000001, 32'h3f800000, `SPF_QNAN, 1'b0);
    run(`SPF_OP_MUL, 32'h8d800000, 32'h2b800000, 32'h80000000, 1'b0);
    run(`SPF_OP_DIV, 32'h3f800000, 32'h0, 32'h7f800000, 1'b0);
    run(`SPF_OP_ADD, 32'h7f800001, 32'h3f800000, `SPF_QNAN, 1'b0);
    run(`SPF_OP_LT, 32'h7fc00000, 32'h3f800000, 32'h0, 1'b0);
    run(`SPF_OP_FINT, 32'h4f000000, 32'h0, `SPF_INT_MAX, 1'b0);
    run(`SPF_OP_SQRT, 32'hbf800000, 32'h0, `SPF_QNAN, 1'b0);
    run(4'he, 32'h3f800000, 32'h3f800000, `SPF_QNAN, 1'b0);
    repeat (2) @(negedge aclk);
    chk(32'h0, {31'h0, irq_ff}, "irq masked");
    run(`SPF_OP_MUL, 32'hff000000, 32'h7f000000, 32'hff800000, 1'b0);
    repeat (2) @(negedge aclk);
    chk(32'h1, {31'h0, irq_ff}, "irq set");
    bus(1'b0, `SPF_OFS_STATUS, 32'h1f, `SPF_RESP_OK);
    bus(1'b0, `SPF_OFS_STATUS, 32'h0, `SPF_RESP_OK);
    repeat (2) @(negedge aclk);
    chk(32'h0, {31'h0, irq_ff}, "irq clear");
  endtask
  task automatic t_trap;
    bus(1'b1, `SPF_OFS_CTRL, 32'h4, `SPF_RESP_OK);
    bus(1'b0, `SPF_OFS_CTRL, 32'h4, `SPF_RESP_OK);
    run(`SPF_OP_MUL, 32'h7f000000, 32'h7f000000, 32'h4, 1'b1);
    run(`SPF_OP_DIV, 32'hbf800000, 32'h0, 32'hff800000, 1'b0);
    run(`SPF_OP_ADD, 32'h3f800000, 32'h3f800000, 32'h40000000, 1'b0);
    bus(1'b1, `SPF_OFS_STATUS, 32'h0, `SPF_RESP_ERR);
    bus(1'b1, 8'h10, 32'h1f, `SPF_RESP_ERR);
    bus(1'b0, `SPF_OFS_STATUS, 32'h6, `SPF_RESP_OK);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    t_reset();
    t_arith();
    t_cmp();
    t_conv();
    t_special();
    t_trap();
    stop_test();
  end
endmodule // testbench
`default_nettype wire
